// file: mst_pkg.sv
// constants for the miscellaneous status and timer register group
package mst_pkg;
  // register byte offsets
  localparam logic [9:0] OFS_BYTE_ORDER = 10'h064;
  localparam logic [9:0] OFS_HW_STATUS  = 10'h074;
  localparam logic [9:0] OFS_TMR_CFG    = 10'h08c;
  localparam logic [9:0] OFS_TMR_CNT    = 10'h090;
  localparam logic [9:0] OFS_FREE_CNT   = 10'h09c;
  // field positions
  localparam int BIT_READY    = 27;
  localparam int BIT_XOVER_P2 = 26;
  localparam int BIT_XOVER_P1 = 25;
  localparam int BIT_TMR_EN   = 29;
  // fixed and reset values
  localparam logic [31:0] BYTE_PATTERN = 32'h87654321;
  localparam logic [15:0] PRELOAD_RST  = 16'hffff;
  localparam logic [31:0] FREE_RST     = 32'h00000000;
  localparam logic [31:0] RDATA_RST    = 32'h00000000;
  // timing
  localparam int CLK_PERIOD_NS     = 40;
  localparam int READY_TIME_NS     = 1000;
  localparam int READY_CYCLES      =
    (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREE_CLEAR_NS     = 160;
  localparam int FREE_CLEAR_CYCLES = FREE_CLEAR_NS / CLK_PERIOD_NS;
  // start-up states
  typedef enum logic {
    MST_SETTLE = 1'b0,
    MST_ACTIVE = 1'b1
  } mst_ready_type;
endpackage

// file: mst_timer.sv
// general purpose down-counting timer with preload and reload
`timescale 1ns/1ps
module mst_timer
  import mst_pkg::*;
(
  input  wire logic        mclk,      // system clock
  input  wire logic        external_reset_pin,      // sync reset, active low
  input  wire logic        en,        // run when high
  input  wire logic [15:0] preload,   // start and reload value
  output logic      [15:0] count_reg, // live count
  output logic             event_reg  // one-cycle expiry pulse
);
  logic        en_d_reg; // enable seen last cycle
  wire         start;    // enable just rose
  wire         wrap;     // running count passes zero
  wire  [15:0] count_next;

  assign start = en & ~en_d_reg;
  assign wrap  = en & en_d_reg & (count_reg == 16'h0000);
  // load on start, reload after zero, else step down while running
  assign count_next = (start | wrap) ? preload :
                      en ? count_reg - 16'h0001 :
                      count_reg;                          // halted

  // count and expiry pulse
  always_ff @(posedge mclk) begin
    if (!external_reset_pin) begin
      count_reg <= PRELOAD_RST;
      event_reg <= 1'b0;
      en_d_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      event_reg <= wrap;
      en_d_reg  <= en;
    end
  end
endmodule // mst_timer

// file: mst_regs.sv
// register group: byte pattern, ready/straps, timer, free counter
// Operation
// - pattern register always returns fixed value
// - pattern readable while not ready, harmlessly
// - reads during reset never return pattern
// - either 16-bit half readable alone
// - ready flag bit 27 sets after settling
// - ready rising edge can raise interrupt
// - writes ignored until ready is set
// - config register pollable in reset, not ready (here only while not ready; reads in reset get no answer)
// - crossover straps latched in reset, loader rewrites
// - timer runs when enable set, halts otherwise
// - enable falling forces preload to ones
// - timer loads preload and counts down
// - timer raises periodic interrupt events
// - live count in low half, upper zero
// - free counter starts zero, counts every cycle
// - free counter wraps to zero, continues
// - free counter clears within 160 ns
`timescale 1ns/1ps
module mst_regs
  import mst_pkg::*;
#(
  parameter int READY_CYC = READY_CYCLES // settling time in cycles
)(
  input  wire logic        mclk,            // 25 MHz system clock
  input  wire logic        external_reset_pin,            // sync reset, active low
  input  wire logic [9:0]  reg_addr,        // register byte address
  input  wire logic        reg_rd,          // read strobe
  input  wire logic        reg_wr,          // write strobe
  input  wire logic [31:0] reg_wdata,       // write data
  input  wire logic        reg_half16,      // 16-bit serial access
  input  wire logic        reg_upper,       // pick upper half
  input  wire logic        strap_xover_p1,  // crossover strap pin 1
  input  wire logic        strap_xover_p2,  // crossover strap pin 2
  input  wire logic        eeprom_strap_wr, // loader rewrites straps
  input  wire logic [1:0]  eeprom_strap_data, // {port2, port1}
  output logic      [31:0] reg_rdata_reg,   // read data
  output logic             reg_ack_reg,     // read answer pulse
  output logic             device_ready_reg, // device ready level
  output logic             ready_rise_reg,  // ready set pulse
  output logic             timer_event      // timer expiry pulse
);
  localparam int CNT_W = $clog2(READY_CYC + 1);

  // address match, used by read and write decode
  function automatic logic hit(input logic [9:0] a,
                               input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [1:0]       sync1_reg;     // strap pins, first stage
  logic [1:0]       sync2_reg;     // strap pins, second stage
  logic [1:0]       xover_reg;     // {port2, port1} strap state
  mst_ready_type    state_reg;     // start-up state
  mst_ready_type    state_next;
  logic [CNT_W-1:0] ready_cnt_reg; // settling counter
  logic             tmr_en_reg;    // timer enable
  logic [15:0]      preload_reg;   // timer preload
  logic [31:0]      free_cnt_reg;  // free running count
  logic [15:0]      tmr_count;     // live timer value
  logic             tmr_event;     // timer expiry from timer

  wire        wr_ok;        // write accepted
  wire        wr_cfg;       // write to timer config
  wire        tmr_en_next;
  wire        tmr_fall;     // enable going 1 to 0
  wire [15:0] preload_next;
  wire        settled;      // settling time elapsed
  wire [31:0] hw_word;      // hardware config image
  wire [31:0] cfg_word;     // timer config image
  wire [31:0] rd_word;      // selected register
  wire [15:0] rd_half;      // selected half
  wire [31:0] rd_data;      // final read value

  // strap pins are asynchronous: two flops before use
  always_ff @(posedge mclk) begin
    sync1_reg <= {strap_xover_p2, strap_xover_p1};
    sync2_reg <= sync1_reg;
  end

  // straps follow the pins throughout reset, so the level
  // at release is kept; the loader may rewrite them later
  always_ff @(posedge mclk) begin
    if (!external_reset_pin) begin
      xover_reg <= sync2_reg;
    end else if (eeprom_strap_wr) begin
      xover_reg <= eeprom_strap_data;
    end
  end

  // start-up: wait out the settling time, then stay active
  assign settled = (ready_cnt_reg == CNT_W'(READY_CYC - 1));
  always_comb begin
    case (state_reg)
      MST_SETTLE: begin
        state_next = settled ? MST_ACTIVE : MST_SETTLE;
      end
      MST_ACTIVE: begin
        state_next = MST_ACTIVE;
      end
      default: begin
        state_next = MST_SETTLE;
      end
    endcase
  end

  // start-up state, counter and ready outputs
  always_ff @(posedge mclk) begin
    if (!external_reset_pin) begin
      state_reg        <= MST_SETTLE;
      ready_cnt_reg    <= '0;
      device_ready_reg <= 1'b0;
      ready_rise_reg   <= 1'b0;
    end else begin
      state_reg        <= state_next;
      ready_cnt_reg    <= settled ? ready_cnt_reg
                                  : ready_cnt_reg + CNT_W'(1);
      device_ready_reg <= (state_next == MST_ACTIVE);
      ready_rise_reg   <= (state_next == MST_ACTIVE) &
                          ~device_ready_reg;
    end
  end

  // writes count only once ready; reserved bits dropped
  assign wr_ok        = reg_wr & device_ready_reg;
  assign wr_cfg       = wr_ok & hit(reg_addr, OFS_TMR_CFG);
  assign tmr_en_next  = wr_cfg ? reg_wdata[BIT_TMR_EN] : tmr_en_reg;
  assign tmr_fall     = tmr_en_reg & ~tmr_en_next;
  // forcing to ones beats a preload written in the same access
  assign preload_next = tmr_fall ? PRELOAD_RST :
                        wr_cfg ? reg_wdata[15:0] :
                        preload_reg;

  // timer configuration
  always_ff @(posedge mclk) begin
    if (!external_reset_pin) begin
      tmr_en_reg  <= 1'b0;
      preload_reg <= PRELOAD_RST;
    end else begin
      tmr_en_reg  <= tmr_en_next;
      preload_reg <= preload_next;
    end
  end

  // the counting itself lives in its own module
  mst_timer u_timer (
    .mclk      (mclk),
    .external_reset_pin      (external_reset_pin),
    .en        (tmr_en_reg),
    .preload   (preload_reg),
    .count_reg (tmr_count),
    .event_reg (tmr_event)
  );
  assign timer_event = tmr_event;

  // free counter wraps on its own from all ones to zero
  always_ff @(posedge mclk) begin
    if (!external_reset_pin) begin
      free_cnt_reg <= FREE_RST;
    end else begin
      free_cnt_reg <= free_cnt_reg + 32'h00000001;
    end
  end

  // read images; reserved bits are zero
  assign hw_word = {4'h0, device_ready_reg, xover_reg,
                    25'h0000000};
  assign cfg_word = {2'h0, tmr_en_reg, 13'h0000, preload_reg};
  assign rd_word =
    hit(reg_addr, OFS_BYTE_ORDER) ? BYTE_PATTERN :
    hit(reg_addr, OFS_HW_STATUS)  ? hw_word :
    hit(reg_addr, OFS_TMR_CFG)    ? cfg_word :
    hit(reg_addr, OFS_TMR_CNT)    ? {16'h0000, tmr_count} :
    hit(reg_addr, OFS_FREE_CNT)   ? free_cnt_reg :
    32'h00000000;                                      // unmapped
  assign rd_half = reg_upper ? rd_word[31:16] : rd_word[15:0];
  assign rd_data = reg_half16 ? {16'h0000, rd_half} : rd_word;

  // read answer one cycle after the strobe; held until next read.
  // reset clears it, so reset-time data never looks valid
  always_ff @(posedge mclk) begin
    if (!external_reset_pin) begin
      reg_rdata_reg <= RDATA_RST;
      reg_ack_reg   <= 1'b0;
    end else begin
      reg_ack_reg <= reg_rd;
      if (reg_rd) begin
        reg_rdata_reg <= rd_data;
      end
    end
  end

  // checks
  property p_pattern;
    @(posedge mclk) disable iff (!external_reset_pin)
    reg_rd && !reg_half16 && reg_addr == OFS_BYTE_ORDER
      |=> reg_ack_reg && reg_rdata_reg == BYTE_PATTERN;
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("pattern read wrong");

  property p_early_read;
    @(posedge mclk) disable iff (!external_reset_pin)
    reg_rd && !device_ready_reg && reg_addr == OFS_HW_STATUS
      && !reg_half16 |=> reg_ack_reg
        && reg_rdata_reg == {4'h0, 1'b0, $past(xover_reg), 25'h0};
  endproperty
  a_early_read: assert property (p_early_read)
    else $error("config read before ready wrong");

  property p_reset_data;
    @(posedge mclk)
    !external_reset_pin |=> reg_rdata_reg != BYTE_PATTERN && !reg_ack_reg;
  endproperty
  a_reset_data: assert property (p_reset_data)
    else $error("valid pattern during reset");

  property p_half;
    @(posedge mclk) disable iff (!external_reset_pin)
    reg_rd && reg_half16 && reg_upper && reg_addr == OFS_BYTE_ORDER
      |=> reg_rdata_reg == {16'h0000, BYTE_PATTERN[31:16]};
  endproperty
  a_half: assert property (p_half)
    else $error("upper half read wrong");

  property p_ready_time;
    @(posedge mclk) disable iff (!external_reset_pin)
    $rose(device_ready_reg) |-> $past(settled) && ready_rise_reg
      ##1 device_ready_reg && !ready_rise_reg;
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("ready set at wrong time");

  property p_no_early_write;
    @(posedge mclk) disable iff (!external_reset_pin)
    reg_wr && !device_ready_reg
      |=> $stable(tmr_en_reg) && $stable(preload_reg);
  endproperty
  a_no_early_write: assert property (p_no_early_write)
    else $error("write taken before ready");

  property p_strap_write;
    @(posedge mclk) disable iff (!external_reset_pin)
    eeprom_strap_wr |=> xover_reg == $past(eeprom_strap_data);
  endproperty
  a_strap_write: assert property (p_strap_write)
    else $error("strap rewrite lost");

  property p_halted;
    @(posedge mclk) disable iff (!external_reset_pin)
    !tmr_en_reg |=> $stable(tmr_count);
  endproperty
  a_halted: assert property (p_halted)
    else $error("timer moved while halted");

  property p_fall_preset;
    @(posedge mclk) disable iff (!external_reset_pin)
    $fell(tmr_en_reg) |-> preload_reg == PRELOAD_RST;
  endproperty
  a_fall_preset: assert property (p_fall_preset)
    else $error("preload not forced on disable");

  property p_start;
    @(posedge mclk) disable iff (!external_reset_pin)
    $rose(tmr_en_reg) |=> tmr_count == $past(preload_reg)
      ##1 tmr_count == $past(tmr_count) - 16'h0001;
  endproperty
  a_start: assert property (p_start)
    else $error("timer start value wrong");

  property p_wrap;
    @(posedge mclk) disable iff (!external_reset_pin)
    tmr_en_reg && $past(tmr_en_reg) && tmr_count == 16'h0000
      |=> timer_event && tmr_count == $past(preload_reg);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("timer reload wrong");

  property p_count_read;
    @(posedge mclk) disable iff (!external_reset_pin)
    reg_rd && !reg_half16 && reg_addr == OFS_TMR_CNT
      |=> reg_rdata_reg == {16'h0000, $past(tmr_count)};
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count read wrong");

  property p_free_step;
    @(posedge mclk) disable iff (!external_reset_pin)
    $past(external_reset_pin) |-> free_cnt_reg == $past(free_cnt_reg) + 32'h1;
  endproperty
  a_free_step: assert property (p_free_step)
    else $error("free counter skipped");

  property p_free_clear;
    @(posedge mclk)
    $rose(external_reset_pin) |-> free_cnt_reg < 32'(FREE_CLEAR_CYCLES);
  endproperty
  a_free_clear: assert property (p_free_clear)
    else $error("free counter not cleared");

  property p_cfg_reserved;
    @(posedge mclk) disable iff (!external_reset_pin)
    reg_rd && !reg_half16 && reg_addr == OFS_TMR_CFG
      |=> reg_rdata_reg[31:30] == 2'h0
        && reg_rdata_reg[28:16] == 13'h0000;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved)
    else $error("reserved bits not zero");
endmodule // mst_regs

// file: mst_host.sv
// host model driving the register port of the status group
`timescale 1ns/1ps
module mst_host
  import mst_pkg::*;
(
  input  wire logic        mclk,         // system clock
  input  wire logic        device_ready, // ready level from device
  output logic      [9:0]  reg_addr,     // register byte address
  output logic             reg_rd,       // read strobe
  output logic             reg_wr,       // write strobe
  output logic      [31:0] reg_wdata,    // write data
  output logic             reg_half16,   // 16-bit serial access
  output logic             reg_upper     // upper half select
);
  // known levels from time zero
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 32'h00000000;
    idle();
  end
  // release the port; address and data flip so stale values never match
  task automatic idle();
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_half16 = 1'b0;
    reg_upper = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // one read, held across exactly one sampling edge
  task automatic read(input logic [9:0] a, input logic h, input logic u);
    // before ready only the pattern and config registers are touched
    if (device_ready !== 1'b1 && a != OFS_BYTE_ORDER && a != OFS_HW_STATUS)
      return;
    reg_addr = a;
    reg_half16 = h;
    reg_upper = u;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge mclk);
    #2;
  endtask
  // one write; an early write happens only when a test asks for it
  task automatic write(input logic [9:0] a, input logic [31:0] d,
                       input logic early);
    if (!early && device_ready !== 1'b1)
      return;
    reg_addr = a;
    reg_wdata = d;
    reg_half16 = 1'b0;
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    @(posedge mclk);
    #2;
  endtask
endmodule // mst_host

// file: misc_status_and_timers_tb_top.sv
// self-checking bench for the status and timer register group
`timescale 1ns/1ps
module misc_status_and_timers_tb_top;
  import mst_pkg::*;
  localparam int RDY = 8;         // shortened settling time
  logic        mclk;              // system clock
  logic        external_reset_pin;              // sync reset, active low
  logic [9:0]  reg_addr;          // from host model
  logic        reg_rd;            // from host model
  logic        reg_wr;            // from host model
  logic [31:0] reg_wdata;         // from host model
  logic        reg_half16;        // from host model
  logic        reg_upper;         // from host model
  logic        strap_xover_p1;    // strap pin port 1
  logic        strap_xover_p2;    // strap pin port 2
  logic        eeprom_strap_wr;   // loader rewrite pulse
  logic [1:0]  eeprom_strap_data; // loader strap values
  logic [31:0] reg_rdata_reg;     // read data
  logic        reg_ack_reg;       // read answer
  logic        device_ready_reg;  // ready level
  logic        ready_rise_reg;    // ready pulse
  logic        timer_event;       // timer expiry
  logic [31:0] tick;              // edges since release
  logic [31:0] exp_q[$];          // expected read data
  logic [31:0] msk_q[$];          // compared bits
  logic [1:0]  st;                // strap levels {p2,p1}
  logic [15:0] p;                 // timer preload
  int          n;                 // cycle count
  int          error_cnt = 0;     // mismatches
  int          n_compared = 0;    // comparisons
  mst_regs #(.READY_CYC(RDY)) u_mst_regs (.mclk(mclk), .external_reset_pin(external_reset_pin),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_half16(reg_half16), .reg_upper(reg_upper),
    .strap_xover_p1(strap_xover_p1), .strap_xover_p2(strap_xover_p2),
    .eeprom_strap_wr(eeprom_strap_wr), .eeprom_strap_data(eeprom_strap_data),
    .reg_rdata_reg(reg_rdata_reg), .reg_ack_reg(reg_ack_reg),
    .device_ready_reg(device_ready_reg), .ready_rise_reg(ready_rise_reg),
    .timer_event(timer_event));
  mst_host u_host (.mclk(mclk), .device_ready(device_ready_reg),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_half16(reg_half16), .reg_upper(reg_upper));
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // edge count since release mirrors the free counter
  always @(posedge mclk) tick <= (external_reset_pin === 1'b1) ? tick + 32'd1 : 32'd0;
  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // note the expectation, then let the host issue the read
  task automatic rd_chk(input logic [9:0] a, input logic h, input logic u,
                        input logic [31:0] e, input logic [31:0] m = '1);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    u_host.read(a, h, u);
  endtask
  // answers are matched in order; an unasked answer is a mismatch
  always @(posedge mclk) begin
    if (reg_ack_reg === 1'b1) begin
      if (exp_q.size() == 0)
        chk_val(32'h0, 32'h1);
      else
        chk_val(exp_q.pop_front(), reg_rdata_reg & msk_q.pop_front());
    end
  end
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #(40 * 4000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    st = 2'($urandom(32'h7cdf));
    st = 2'($urandom);
    strap_xover_p1 = st[0];
    strap_xover_p2 = st[1];
    eeprom_strap_wr = 1'b0;
    eeprom_strap_data = 2'b00;
    external_reset_pin = 1'b0;
    repeat (4) @(posedge mclk);
    #2;
    // polling in reset gives no answer and no pattern
    u_host.read(OFS_BYTE_ORDER, 1'b0, 1'b0);
    u_host.idle();
    @(posedge mclk);
    #2;
    chk_val(32'h0, reg_rdata_reg);
    external_reset_pin = 1'b1;
    @(posedge mclk);
    #2;
    // not ready yet: only pattern and config are read
    rd_chk(OFS_BYTE_ORDER, 1'b0, 1'b0, BYTE_PATTERN);
    rd_chk(OFS_HW_STATUS, 1'b0, 1'b0, {4'h0, 1'b0, st, 25'h0});
    rd_chk(OFS_BYTE_ORDER, 1'b1, 1'b1, 32'h00008765);
    rd_chk(OFS_BYTE_ORDER, 1'b1, 1'b0, 32'h00004321);
    u_host.write(OFS_TMR_CFG, 32'h20000005, 1'b1);
    rd_chk(OFS_HW_STATUS, 1'b1, 1'b1, {21'h0, st, 9'h0});
    u_host.idle();
    n = 0;
    while (device_ready_reg !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #2;
      n++;
    end
    chk_val(32'h1, 32'(ready_rise_reg));
    chk_val(32'(RDY), tick);
    rd_chk(OFS_HW_STATUS, 1'b0, 1'b0, {4'h0, 1'b1, st, 25'h0});
    rd_chk(OFS_TMR_CFG, 1'b0, 1'b0, 32'h0000ffff);
    rd_chk(OFS_TMR_CNT, 1'b0, 1'b0, 32'h0000ffff);
    rd_chk(OFS_FREE_CNT, 1'b0, 1'b0, tick);
    rd_chk(10'h100, 1'b0, 1'b0, 32'h0);
    u_host.write(OFS_BYTE_ORDER, 32'h0, 1'b0);
    rd_chk(OFS_BYTE_ORDER, 1'b0, 1'b0, BYTE_PATTERN);
    u_host.idle();
    // loader rewrites both strap bits
    eeprom_strap_data = ~st;
    eeprom_strap_wr = 1'b1;
    @(posedge mclk);
    #2;
    eeprom_strap_wr = 1'b0;
    st = ~st;
    @(posedge mclk);
    #2;
    rd_chk(OFS_HW_STATUS, 1'b0, 1'b0, {4'h0, 1'b1, st, 25'h0});
    // enable with reserved bits set; measure start and period
    p = 16'(3 + $urandom % 16);
    u_host.write(OFS_TMR_CFG, 32'hffff0000 | 32'(p), 1'b0);
    u_host.idle();
    n = 0;
    while (timer_event !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #2;
      n++;
    end
    chk_val(32'(p) + 32'd2, 32'(n));
    n = 0;
    do begin
      @(posedge mclk);
      #2;
      n++;
    end while (timer_event !== 1'b1 && n < 100);
    chk_val(32'(p) + 32'd1, 32'(n));
    rd_chk(OFS_TMR_CFG, 1'b0, 1'b0, {16'h2000, p});
    rd_chk(OFS_TMR_CNT, 1'b0, 1'b0, 32'h0, 32'hffff0000);
    // disable beats the written preload; timer stays quiet
    u_host.write(OFS_TMR_CFG, 32'h00001234, 1'b0);
    rd_chk(OFS_TMR_CFG, 1'b0, 1'b0, 32'h0000ffff);
    u_host.idle();
    @(posedge mclk);
    #2;
    n = 0;
    repeat (2 * p + 8) begin
      @(posedge mclk);
      #2;
      if (timer_event === 1'b1)
        n++;
    end
    chk_val(32'h0, 32'(n));
    repeat (3) @(posedge mclk);
    give_verdict();
  end
endmodule // misc_status_and_timers_tb_top
